// ===== hw/tis_pkg.sv
// Shared constants and types for the tuner two-wire register port
package tis_pkg;
    // Device address: six fixed upper bits, strap fills the lowest
    localparam logic [5:0] DEV_ADDR_HI = 6'h30;
    // Register map seen through the serial port
    localparam logic [7:0] REG_TRACK_CAPS = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h11;
    localparam logic [7:0] NUM_RW_REGS = 8'h10;
    localparam logic [7:0] TRACK_CAPS_RST = 8'h3f;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int POR_BIT = 7;
    localparam int CAP_ONE_MSB = 5;
    localparam int CAP_ONE_LSB = 3;
    localparam int CAP_TWO_MSB = 2;
    localparam int CAP_TWO_LSB = 0;
    // Serial clock timing, host side
    localparam int SCL_MIN_PERIOD_NS = 2500;
    localparam int MCLK_PERIOD_NS = 4;
    localparam logic [7:0] SCL_QTR_CYC =
        8'((SCL_MIN_PERIOD_NS + 4 * MCLK_PERIOD_NS - 1) / (4 * MCLK_PERIOD_NS));
    // Host command port map and command codes
    localparam logic [1:0] HR_CMD = 2'h0;
    localparam logic [1:0] HR_TXD = 2'h1;
    localparam logic [1:0] HR_STAT = 2'h2;
    localparam logic [1:0] HR_RXD = 2'h3;
    localparam logic [2:0] CMD_START = 3'h1;
    localparam logic [2:0] CMD_STOP = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h4;
    localparam int CMD_NACK_BIT = 3;

    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_ADDR = 3'b001,
        DS_PTR = 3'b010,
        DS_WDAT = 3'b011,
        DS_RDAT = 3'b100,
        DS_IGN = 3'b101
    } tis_dev_state_type;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_START = 2'b01,
        HS_STOP = 2'b10,
        HS_BIT = 2'b11
    } tis_host_state_type;
endpackage

// ===== hw/tis_if.sv
// Two-wire bus between host and tuner port, open-drain resolved
`timescale 1ns/1ps
interface tis_if;
    logic scl;
    logic sda;
    logic scl_o;
    logic scl_oe;
    logic sda_o_m;
    logic sda_oe_m;
    logic sda_o_s;
    logic sda_oe_s;

    // Pull-ups win unless an enabled driver pulls low
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));

    modport master (
        output scl_o,
        output scl_oe,
        output sda_o_m,
        output sda_oe_m,
        input scl,
        input sda
    );
    modport slave (
        output sda_o_s,
        output sda_oe_s,
        input scl,
        input sda
    );
endinterface

// ===== hw/tis_dev_end.sv
// Tuner side of the two-wire register port with its register file
`timescale 1ns/1ps
module tis_dev_end
    import tis_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic addr_strap,
    input wire logic [6:0] stat_in,
    output logic [2:0] track_cap_one_weight,
    output logic [2:0] track_cap_two_weight,
    output logic por_flag,
    tis_if.slave bus
);
    logic [2:0] pin_raw;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_f_q;
    logic [2:0] pin_p_q;
    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [6:0] own_addr;
    tis_dev_state_type state_q;
    logic [3:0] bitcnt_q;
    logic ackph_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic mack_q;
    logic sda_oe_q;
    logic stat_rd_q;
    logic por_q;
    logic wr_en;
    logic [7:0] rd_byte;
    logic [7:0] regs [0:15];

    // Strap is a pin too, so it rides the same three-stage filter
    assign pin_raw = {addr_strap, bus.scl, bus.sda};

    // Three-stage sync per line; filtered level moves when stages 2/3 agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (rst) begin
                    pin_s1_q[gi] <= 1'b1;
                    pin_s2_q[gi] <= 1'b1;
                    pin_s3_q[gi] <= 1'b1;
                    pin_f_q[gi] <= 1'b1;
                    pin_p_q[gi] <= 1'b1;
                end else if (ce) begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                    pin_s3_q[gi] <= pin_s2_q[gi];
                    if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                        pin_f_q[gi] <= pin_s3_q[gi];
                    end
                    pin_p_q[gi] <= pin_f_q[gi];
                end
            end
        end
    endgenerate

    assign scl_f = pin_f_q[1];
    assign sda_f = pin_f_q[0];
    assign scl_rise = scl_f && !pin_p_q[1];
    assign scl_fall = !scl_f && pin_p_q[1];
    assign start_c = scl_f && pin_p_q[1] && pin_p_q[0] && !sda_f;
    assign stop_c = scl_f && pin_p_q[1] && !pin_p_q[0] && sda_f;

    assign own_addr = {DEV_ADDR_HI, pin_f_q[2]};

    // Byte for the master at the current pointer
    always_comb begin
        rd_byte = 8'h00;
        if (ptr_q == REG_STATUS) begin
            rd_byte = {por_q, stat_in};
        end else if (ptr_q < NUM_RW_REGS) begin
            rd_byte = regs[ptr_q[3:0]];
        end
    end

    assign wr_en = ce && scl_fall && !ackph_q && (bitcnt_q == 4'h8)
        && (state_q == DS_WDAT) && !stop_c && !start_c;

    // Register file; only the low sixteen locations take writes
    generate
        for (gi = 0; gi < 16; gi++) begin : g_regs
            always_ff @(posedge mclk) begin
                if (rst) begin
                    regs[gi] <= (gi == int'(REG_TRACK_CAPS)) ?
                        TRACK_CAPS_RST : REG_RST;
                end else if (wr_en && ptr_q == 8'(gi)) begin
                    regs[gi] <= sh_q;
                end
            end
        end
    endgenerate

    // Serial engine: bits taken on clock rise, driven after clock fall
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= DS_IDLE;
            bitcnt_q <= 4'h0;
            ackph_q <= 1'b0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            stat_rd_q <= 1'b0;
        end else if (ce) begin
            if (stop_c) begin
                state_q <= DS_IDLE;
                sda_oe_q <= 1'b0;
                stat_rd_q <= 1'b0;
            end else if (start_c) begin
                state_q <= DS_ADDR;
                bitcnt_q <= 4'h0;
                ackph_q <= 1'b0;
                sda_oe_q <= 1'b0;
                stat_rd_q <= 1'b0;
            end else if (state_q != DS_IDLE && state_q != DS_IGN) begin
                if (scl_rise) begin
                    if (ackph_q) begin
                        mack_q <= !sda_f;
                    end else if (bitcnt_q != 4'h8) begin
                        sh_q <= {sh_q[6:0], sda_f};
                        bitcnt_q <= bitcnt_q + 4'h1;
                    end
                end else if (scl_fall) begin
                    if (!ackph_q && bitcnt_q == 4'h8) begin
                        ackph_q <= 1'b1;
                        case (state_q)
                            DS_ADDR: begin
                                if (sh_q[7:1] == own_addr) begin
                                    sda_oe_q <= 1'b1;
                                    rw_q <= sh_q[0];
                                end else begin
                                    state_q <= DS_IGN;
                                end
                            end
                            DS_PTR: begin
                                ptr_q <= sh_q;
                                sda_oe_q <= 1'b1;
                            end
                            DS_WDAT: begin
                                ptr_q <= ptr_q + 8'h01;
                                sda_oe_q <= 1'b1;
                            end
                            default: begin
                                sda_oe_q <= 1'b0;
                            end
                        endcase
                    end else if (ackph_q) begin
                        ackph_q <= 1'b0;
                        bitcnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        case (state_q)
                            DS_ADDR: begin
                                if (rw_q) begin
                                    state_q <= DS_RDAT;
                                    tx_q <= rd_byte;
                                    ptr_q <= ptr_q + 8'h01;
                                    sda_oe_q <= !rd_byte[7];
                                    stat_rd_q <= stat_rd_q
                                        || (ptr_q == REG_STATUS);
                                end else begin
                                    state_q <= DS_PTR;
                                end
                            end
                            DS_PTR: state_q <= DS_WDAT;
                            DS_RDAT: begin
                                if (mack_q) begin
                                    tx_q <= rd_byte;
                                    ptr_q <= ptr_q + 8'h01;
                                    sda_oe_q <= !rd_byte[7];
                                    stat_rd_q <= stat_rd_q
                                        || (ptr_q == REG_STATUS);
                                end else begin
                                    state_q <= DS_IGN;
                                end
                            end
                            default: state_q <= state_q;
                        endcase
                    end else if (state_q == DS_RDAT) begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= !tx_q[6];
                    end
                end
            end
        end
    end

    // Power-on flag survives until status was read and a stop closed it
    always_ff @(posedge mclk) begin
        if (rst) begin
            por_q <= 1'b1;
        end else if (ce && stop_c && stat_rd_q) begin
            por_q <= 1'b0;
        end
    end

    // Open-drain: only ever pulls low
    assign bus.sda_o_s = 1'b0;
    assign bus.sda_oe_s = sda_oe_q;
    assign track_cap_one_weight =
        regs[REG_TRACK_CAPS[3:0]][CAP_ONE_MSB:CAP_ONE_LSB];
    assign track_cap_two_weight =
        regs[REG_TRACK_CAPS[3:0]][CAP_TWO_MSB:CAP_TWO_LSB];
    assign por_flag = por_q;
endmodule // tis_dev_end

// ===== hw/tis_host_end.sv
// Host side: byte-level two-wire master driven by a command port
`timescale 1ns/1ps
module tis_host_end
    import tis_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    tis_if.master bus
);
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_s3_q;
    logic sda_f_q;
    tis_host_state_type hs_q;
    logic [7:0] qcnt_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic op_rd_q;
    logic ackbit_q;
    logic nack_q;
    logic [7:0] sh_q;
    logic [7:0] txd_q;
    logic [7:0] rxd_q;
    logic [7:0] rdata_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic tick;
    logic cmd_wr;

    // Data pin sync; stage 1 feeds stage 2 only
    always_ff @(posedge mclk) begin
        if (rst) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else if (ce) begin
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            if (sda_s2_q == sda_s3_q) begin
                sda_f_q <= sda_s3_q;
            end
        end
    end

    assign tick = (qcnt_q == SCL_QTR_CYC - 8'h01);
    assign cmd_wr = wr && (addr == HR_CMD);

    // Transmit byte holding register
    always_ff @(posedge mclk) begin
        if (rst) begin
            txd_q <= 8'h00;
        end else if (ce && wr && addr == HR_TXD) begin
            txd_q <= wdata;
        end
    end

    // Bus sequencer; each phase lasts a quarter of the clock period
    always_ff @(posedge mclk) begin
        if (rst) begin
            hs_q <= HS_IDLE;
            qcnt_q <= 8'h00;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            op_rd_q <= 1'b0;
            ackbit_q <= 1'b0;
            nack_q <= 1'b0;
            sh_q <= 8'h00;
            rxd_q <= 8'h00;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (ce) begin
            if (hs_q == HS_IDLE) begin
                qcnt_q <= 8'h00;
                ph_q <= 2'h0;
                bit_q <= 4'h0;
                // Commands while busy are dropped, not queued
                if (cmd_wr) begin
                    if (wdata[2:0] == CMD_START) begin
                        hs_q <= HS_START;
                        nack_q <= 1'b0;
                    end else if (wdata[2:0] == CMD_STOP) begin
                        hs_q <= HS_STOP;
                    end else if (wdata[2:0] == CMD_WRITE && !nack_q) begin
                        hs_q <= HS_BIT;
                        op_rd_q <= 1'b0;
                        sh_q <= txd_q;
                    end else if (wdata[2:0] == CMD_READ && !nack_q) begin
                        hs_q <= HS_BIT;
                        op_rd_q <= 1'b1;
                        ackbit_q <= wdata[CMD_NACK_BIT];
                    end
                end
            end else if (!tick) begin
                qcnt_q <= qcnt_q + 8'h01;
            end else begin
                qcnt_q <= 8'h00;
                ph_q <= ph_q + 2'h1;
                case (hs_q)
                    HS_START: begin
                        case (ph_q)
                            2'h0: sda_oe_q <= 1'b0;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b1;
                            default: begin
                                scl_oe_q <= 1'b1;
                                hs_q <= HS_IDLE;
                            end
                        endcase
                    end
                    HS_STOP: begin
                        case (ph_q)
                            2'h0: sda_oe_q <= 1'b1;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b0;
                            default: hs_q <= HS_IDLE;
                        endcase
                    end
                    default: begin
                        case (ph_q)
                            2'h0: begin
                                if (bit_q == 4'h8) begin
                                    sda_oe_q <= op_rd_q && !ackbit_q;
                                end else begin
                                    sda_oe_q <= !op_rd_q && !sh_q[7];
                                end
                            end
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: begin
                                if (bit_q != 4'h8) begin
                                    sh_q <= {sh_q[6:0], sda_f_q};
                                end else if (!op_rd_q && sda_f_q) begin
                                    nack_q <= 1'b1;
                                end
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                if (bit_q == 4'h8) begin
                                    hs_q <= HS_IDLE;
                                    sda_oe_q <= 1'b0;
                                    if (op_rd_q) begin
                                        rxd_q <= sh_q;
                                    end
                                end else begin
                                    bit_q <= bit_q + 4'h1;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    // Read data appears in the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (ce) begin
            rdata_q <= 8'h00;
            if (rd) begin
                if (addr == HR_TXD) begin
                    rdata_q <= txd_q;
                end else if (addr == HR_STAT) begin
                    rdata_q <= {6'h00, nack_q, hs_q != HS_IDLE};
                end else if (addr == HR_RXD) begin
                    rdata_q <= rxd_q;
                end
            end
        end
    end

    assign rdata = rdata_q;
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = scl_oe_q;
    assign bus.sda_o_m = 1'b0;
    assign bus.sda_oe_m = sda_oe_q;
endmodule // tis_host_end

// ===== tb/tis_chk.sv
// Bus-level checks on the two-wire link between host and tuner
`timescale 1ns/1ps
module tis_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o_m,
    input wire logic sda_oe_m,
    input wire logic sda_o_s,
    input wire logic sda_oe_s
);
    logic [10:0] per_q;
    logic [3:0] bit_q;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Cycles since last clock rise; saturates so the first rise passes
    always_ff @(posedge mclk) begin
        if (rst) per_q <= 11'h7ff;
        else if ($rose(scl)) per_q <= 11'h000;
        else if (per_q != 11'h7ff) per_q <= per_q + 11'h001;
    end
    // Clock rises modulo nine; stop adds one rise before it
    always_ff @(posedge mclk) begin
        if (rst) bit_q <= 4'h0;
        else if (scl && ($fell(sda) || $rose(sda))) bit_q <= 4'h0;
        else if ($rose(scl)) bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
    end
    a_pins_drain: assert property (!sda_o_s && !sda_o_m && !scl_o)
        else $error("a bus pin drives high");
    a_host_stable: assert property (scl && $past(scl) &&
        $changed(sda_oe_m) |-> bit_q <= 4'h1)
        else $error("host data moved, clock high");
    a_idle_free: assert property (per_q == 11'h7ff |-> !sda_oe_s)
        else $error("device drives an idle bus");
    a_reset_free: assert property ($past(rst) |->
        !scl_oe && !sda_oe_m && !sda_oe_s) else $error("bus held at reset");
    a_dev_stable: assert property (scl && $past(scl) |->
        $stable(sda_oe_s)) else $error("device data moved, clock high");
    a_dev_nostart: assert property (scl && $fell(sda) |->
        !sda_oe_s) else $error("device made a start");
    a_stop_host: assert property (scl && $rose(sda) |->
        $past(sda_oe_m) && !$past(sda_oe_s)) else $error("stop not by host");
    a_scl_period: assert property ($rose(scl) |->
        per_q >= 11'h270) else $error("clock period too short");
    a_byte_nine: assert property (scl && $rose(sda) |->
        bit_q == 4'h1) else $error("stop inside a byte");
    a_start_bits: assert property (scl && $fell(sda) |->
        bit_q <= 4'h1) else $error("start inside a byte");
    c_start: cover property (scl && $fell(sda));
    c_stop: cover property (scl && $rose(sda));
    c_ack: cover property ($rose(scl) && sda_oe_s && bit_q == 4'h8);
    c_rdat: cover property ($rose(scl) && sda_oe_s && bit_q != 4'h8);
endmodule // tis_chk

// ===== tb/tuner_i2c_register_slave_test.sv
// Testbench: host end drives tuner end across the shared bus
`timescale 1ns/1ps
module tuner_i2c_register_slave_test
    import tis_pkg::*;
;
    localparam logic [7:0] ST = {5'h0, CMD_START};
    localparam logic [7:0] SP = {5'h0, CMD_STOP};
    localparam logic [7:0] WR = {5'h0, CMD_WRITE};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic strap = 1'b0;
    logic [6:0] stat_in = 7'h25;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [2:0] w1;
    logic [2:0] w2;
    logic por_flag;
    logic [7:0] st;
    int num_errors = 0;
    int comparisons = 0;
    // 250 MHz system clock
    always #2 mclk = ~mclk;
    tis_if u_tis_if ();
    tis_host_end u_tis_host_end (.mclk(mclk), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .bus(u_tis_if.master));
    tis_dev_end u_tis_dev_end (.mclk(mclk), .rst(rst), .ce(ce),
        .addr_strap(strap), .stat_in(stat_in), .track_cap_one_weight(w1),
        .track_cap_two_weight(w2), .por_flag(por_flag),
        .bus(u_tis_if.slave));
    tis_chk u_tis_chk (.mclk(mclk), .rst(rst), .scl(u_tis_if.scl),
        .sda(u_tis_if.sda), .scl_o(u_tis_if.scl_o),
        .scl_oe(u_tis_if.scl_oe), .sda_o_m(u_tis_if.sda_o_m),
        .sda_oe_m(u_tis_if.sda_oe_m), .sda_o_s(u_tis_if.sda_o_s),
        .sda_oe_s(u_tis_if.sda_oe_s));
    task automatic test_done;
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One-cycle strobes; an idle edge follows so no strobe is set twice
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rreg(input logic [1:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
    endtask
    // Issue a command and poll busy under a bound
    task automatic xfer(input logic [7:0] c, input logic [7:0] tx);
        int n;
        n = 0;
        wreg(HR_TXD, tx);
        wreg(HR_CMD, c);
        st = 8'h01;
        while (st[0] !== 1'b0 && n < 5000) begin
            rreg(HR_STAT, st);
            n++;
        end
        if (n >= 5000) begin
            num_errors++;
            test_done;
        end
    endtask
    task automatic op(input logic [7:0] c, tx, input logic nk);
        xfer(c, tx);
        chk("ack bit", {7'h0, st[1]}, {7'h0, nk});
    endtask
    task automatic rdb(input logic nk, input logic [7:0] e);
        logic [7:0] d;
        xfer({4'h0, nk, CMD_READ}, 8'h00);
        rreg(HR_RXD, d);
        chk("read byte", d, e);
    endtask
    task automatic t_write;
        chk("reset caps", {2'h0, w1, w2}, 8'h3f);
        xfer(ST, 8'h00);
        op(WR, 8'hc0, 1'b0);
        op(WR, 8'h04, 1'b0);
        op(WR, 8'h2a, 1'b0);
        op(WR, 8'h15, 1'b0);
        xfer(SP, 8'h00);
        chk("cap one", {5'h0, w1}, 8'h05);
        chk("cap two", {5'h0, w2}, 8'h02);
        $display("write test done");
    endtask
    // Pointer write, repeated start, then the read address; callers read the bytes
    task automatic t_rd(input logic [7:0] p);
        xfer(ST, 8'h00);
        op(WR, 8'hc0, 1'b0);
        op(WR, p, 1'b0);
        xfer(ST, 8'h00);
        op(WR, 8'hc1, 1'b0);
    endtask
    task automatic t_read;
        t_rd(8'h04);
        rdb(1'b0, 8'h2a);
        rdb(1'b1, 8'h15);
        xfer(SP, 8'h00);
        $display("read test done");
    endtask
    task automatic t_other;
        xfer(ST, 8'h00);
        op(WR, 8'hc2, 1'b1);
        // Host must refuse further bytes once a nack was seen
        wreg(HR_CMD, WR);
        rreg(HR_STAT, st);
        chk("write refused", st, 8'h02);
        xfer(SP, 8'h00);
        $display("address test done");
    endtask
    // Flag survives until the stop that closes the status read
    task automatic t_por;
        chk("por set", {7'h0, por_flag}, 8'h01);
        t_rd(8'h11);
        rdb(1'b1, {1'b1, stat_in});
        chk("por held", {7'h0, por_flag}, 8'h01);
        xfer(SP, 8'h00);
        repeat (8) @(posedge mclk);
        chk("por clear", {7'h0, por_flag}, 8'h00);
        $display("power flag test done");
    endtask
    // Second reset with the strap high; the frozen host must drop commands
    task automatic t_strap;
        strap <= 1'b1;
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("por again", {7'h0, por_flag}, 8'h01);
        chk("caps again", {2'h0, w1, w2}, 8'h3f);
        ce <= 1'b0;
        wreg(HR_CMD, ST);
        ce <= 1'b1;
        rreg(HR_STAT, st);
        chk("frozen host", st, 8'h00);
        xfer(ST, 8'h00);
        op(WR, 8'hc2, 1'b0);
        xfer(SP, 8'h00);
        $display("strap test done");
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_write;
        t_read;
        t_other;
        t_por;
        t_strap;
        test_done;
    end
endmodule // tuner_i2c_register_slave_test
